// ### logic/scan_port_defs.vh
`ifndef SCAN_PORT_DEFS_VH
`define SCAN_PORT_DEFS_VH

// --------------------------------------------------------------------------
// controller states (4-bit binary codes)
// --------------------------------------------------------------------------
`define TS_RESET      4'h0
`define TS_IDLE       4'h1
`define TS_SEL_DR     4'h2
`define TS_CAP_DR     4'h3
`define TS_SHIFT_DR   4'h4
`define TS_EXIT1_DR   4'h5
`define TS_PAUSE_DR   4'h6
`define TS_EXIT2_DR   4'h7
`define TS_UPD_DR     4'h8
`define TS_SEL_IR     4'h9
`define TS_CAP_IR     4'hA
`define TS_SHIFT_IR   4'hB
`define TS_EXIT1_IR   4'hC
`define TS_PAUSE_IR   4'hD
`define TS_EXIT2_IR   4'hE
`define TS_UPD_IR     4'hF

// --------------------------------------------------------------------------
// instruction register
// --------------------------------------------------------------------------
`define IR_WIDTH      4
`define IR_CAPTURE    4'h1
`define IR_BYPASS     4'hF
`define IR_IDCODE     4'h2
`define IR_EXTEST     4'h0
`define IR_SAMPLE     4'h3

`endif

// ### logic/scan_test_port.v
// What this block does
// - low test reset resets controller, instruction, pin_test_r and tdo enable after its two-stage clk synchroniser, with no tck edge needed
// - mode select sampled on each test clock rising edge steers the controller
// - serial data input captured on each test clock rising edge
// - serial data output updated on each test clock falling edge
// - data output enabled at the first test clock falling edge in a shift state, released at the first falling edge after it
// - open reset, mode select and data input read as high
`timescale 1ns/1ps
`include "scan_port_defs.vh"

module scan_test_port #(
    parameter        BSR_LEN = 8,
    parameter [31:0] ID_CODE = 32'h0000_0001  // arbitrary neutral value
) (
    input  wire               clk,
    input  wire               rst_n,
    input  wire               ce,
    input  wire               tck,
    input  wire               tms,
    input  wire               tms_oe,
    input  wire               tdi,
    input  wire               tdi_oe,
    input  wire               trst_n,
    input  wire               trst_oe,
    input  wire [BSR_LEN-1:0] pin_in,
    output reg                tdo_r,
    output reg                tdo_oe,
    output reg  [BSR_LEN-1:0] pin_out,
    output reg                pin_test_r,
    output reg  [3:0]         tap_state_r
);

    // ----------------------------------------------------------------------
    // pull-ups and input synchronisers
    // ----------------------------------------------------------------------
    // undriven pins float high through the pull-ups
    // one pad each, so the pull-up mux stands ahead of the sync
    wire tms_pin  = tms_oe  ? tms    : 1'b1;
    wire tdi_pin  = tdi_oe  ? tdi    : 1'b1;
    wire trst_pin = trst_oe ? trst_n : 1'b1;

    reg [1:0] tck_s_r;
    reg [1:0] tms_s_r;
    reg [1:0] tdi_s_r;
    reg [1:0] trst_s_r;
    reg       tck_d_r;

    // two-stage synchronisers; logic reads only the second stage
    // tck stages reset to its idle high level, so no false edge follows reset
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tck_s_r  <= 2'h3;
            tms_s_r  <= 2'h3;
            tdi_s_r  <= 2'h3;
            trst_s_r <= 2'h0;
            tck_d_r  <= 1'b1;
        end else if (ce) begin
            tck_s_r  <= {tck_s_r[0], tck};
            tms_s_r  <= {tms_s_r[0], tms_pin};
            tdi_s_r  <= {tdi_s_r[0], tdi_pin};
            trst_s_r <= {trst_s_r[0], trst_pin};
            tck_d_r  <= tck_s_r[1];
        end
    end

    wire tck_rise = tck_s_r[1] & ~tck_d_r;
    wire tck_fall = ~tck_s_r[1] & tck_d_r;
    wire tms_q    = tms_s_r[1];
    wire tdi_q    = tdi_s_r[1];
    // test reset acts alone, without any tck edge
    wire tap_rst  = ~trst_s_r[1];

    // ----------------------------------------------------------------------
    // controller next state
    // ----------------------------------------------------------------------
    function [3:0] next_state;
        input [3:0] s;
        input       m;
        begin
            case (s)
                `TS_RESET:    next_state = m ? `TS_RESET   : `TS_IDLE;
                `TS_IDLE:     next_state = m ? `TS_SEL_DR  : `TS_IDLE;
                `TS_SEL_DR:   next_state = m ? `TS_SEL_IR  : `TS_CAP_DR;
                `TS_CAP_DR:   next_state = m ? `TS_EXIT1_DR : `TS_SHIFT_DR;
                `TS_SHIFT_DR: next_state = m ? `TS_EXIT1_DR : `TS_SHIFT_DR;
                `TS_EXIT1_DR: next_state = m ? `TS_UPD_DR  : `TS_PAUSE_DR;
                `TS_PAUSE_DR: next_state = m ? `TS_EXIT2_DR : `TS_PAUSE_DR;
                `TS_EXIT2_DR: next_state = m ? `TS_UPD_DR  : `TS_SHIFT_DR;
                `TS_UPD_DR:   next_state = m ? `TS_SEL_DR  : `TS_IDLE;
                `TS_SEL_IR:   next_state = m ? `TS_RESET   : `TS_CAP_IR;
                `TS_CAP_IR:   next_state = m ? `TS_EXIT1_IR : `TS_SHIFT_IR;
                `TS_SHIFT_IR: next_state = m ? `TS_EXIT1_IR : `TS_SHIFT_IR;
                `TS_EXIT1_IR: next_state = m ? `TS_UPD_IR  : `TS_PAUSE_IR;
                `TS_PAUSE_IR: next_state = m ? `TS_EXIT2_IR : `TS_PAUSE_IR;
                `TS_EXIT2_IR: next_state = m ? `TS_UPD_IR  : `TS_SHIFT_IR;
                `TS_UPD_IR:   next_state = m ? `TS_SEL_DR  : `TS_IDLE;
                default:      next_state = `TS_RESET;
            endcase
        end
    endfunction

    // next state for the coming tck rise
    wire [3:0] tap_state_nxt = next_state(tap_state_r, tms_q);

    // ----------------------------------------------------------------------
    // shift paths
    // ----------------------------------------------------------------------
    reg [`IR_WIDTH-1:0] ir_sh_r;
    reg [`IR_WIDTH-1:0] ir_r;
    reg                 byp_r;
    reg [31:0]          id_sh_r;
    reg [BSR_LEN-1:0]   bsr_sh_r;
    reg                 sel_out;

    wire is_bsr = (ir_r == `IR_EXTEST) | (ir_r == `IR_SAMPLE);
    wire is_id  = (ir_r == `IR_IDCODE);

    // serial output source for the current state
    always @* begin
        if (tap_state_r == `TS_SHIFT_IR)
            sel_out = ir_sh_r[0];
        else if (is_id)
            sel_out = id_sh_r[0];
        else if (is_bsr)
            sel_out = bsr_sh_r[0];
        else
            sel_out = byp_r;
    end

    // controller state on tck rising edges
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tap_state_r <= `TS_RESET;
        end else if (ce) begin
            if (tap_rst) begin
                tap_state_r <= `TS_RESET;
            end else if (tck_rise) begin
                tap_state_r <= tap_state_nxt;
            end
        end
    end

    // instruction capture, shift and update
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ir_sh_r    <= `IR_CAPTURE;
            ir_r       <= `IR_IDCODE;
            pin_test_r <= 1'b0;
        end else if (ce) begin
            if (tap_rst) begin
                ir_r       <= `IR_IDCODE;
                pin_test_r <= 1'b0;
            end else if (tck_rise) begin
                case (tap_state_r)
                    `TS_CAP_IR: begin
                        ir_sh_r <= `IR_CAPTURE;
                    end
                    `TS_SHIFT_IR: begin
                        ir_sh_r <= {tdi_q, ir_sh_r[`IR_WIDTH-1:1]};
                    end
                    `TS_UPD_IR: begin
                        ir_r       <= ir_sh_r;
                        pin_test_r <= (ir_sh_r == `IR_EXTEST);
                    end
                    default: begin
                        // entering reset restores the default instruction at once
                        if (tap_state_nxt == `TS_RESET) begin
                            ir_r       <= `IR_IDCODE;
                            pin_test_r <= 1'b0;
                        end
                    end
                endcase
            end
        end
    end

    // data capture, shift and update on tck rising edges
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            byp_r    <= 1'b0;
            id_sh_r  <= 32'h0000_0000;
            bsr_sh_r <= {BSR_LEN{1'b0}};
            pin_out  <= {BSR_LEN{1'b0}};
        end else if (ce && tck_rise && !tap_rst) begin
            case (tap_state_r)
                `TS_CAP_DR: begin
                    byp_r    <= 1'b0;
                    id_sh_r  <= ID_CODE;
                    bsr_sh_r <= pin_in;
                end
                `TS_SHIFT_DR: begin
                    byp_r    <= tdi_q;
                    id_sh_r  <= {tdi_q, id_sh_r[31:1]};
                    bsr_sh_r <= {tdi_q, bsr_sh_r[BSR_LEN-1:1]};
                end
                `TS_UPD_DR: begin
                    if (is_bsr)
                        pin_out <= bsr_sh_r;
                end
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------------
    // serial output on tck falling edges
    // ----------------------------------------------------------------------
    // tdo enable is taken from the two shift states at each tck fall, so it lags them by half a tck period
    wire shifting = (tap_state_r == `TS_SHIFT_DR) | (tap_state_r == `TS_SHIFT_IR);

    // registered tdo and its enable
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tdo_r  <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (ce) begin
            if (tap_rst) begin
                tdo_oe <= 1'b0;
            end else if (tck_fall) begin
                tdo_r  <= sel_out;
                tdo_oe <= shifting;
            end
        end
    end

endmodule

// ### sim/scan_port_props.sv
`timescale 1ns/1ps
`include "scan_port_defs.vh"
// ----------------------------------------
// port checks
// ----------------------------------------
module scan_port_props (
    input wire       clk,
    input wire       rst_n,
    input wire       tck,
    input wire       trst_n,
    input wire       trst_oe,
    input wire       tdo_oe,
    input wire [3:0] tap_state_r
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    a_trst_forces_reset: assert property ((trst_oe && !trst_n)[*4] |=> tap_state_r == `TS_RESET && !tdo_oe)
        else $error("trst did not reset port");
    a_reset_release: assert property ($rose(rst_n) |-> tap_state_r == `TS_RESET && !tdo_oe)
        else $error("port not idle after reset");
    a_edge_moves_state: assert property ($changed(tap_state_r) && tap_state_r != `TS_RESET |-> $past(tck, 2))
        else $error("state moved without tck rise");
    a_oe_on_fall: assert property ($rose(tdo_oe) |-> !$past(tck, 2))
        else $error("tdo enabled off a fall");
    a_oe_only_shift: assert property (tdo_oe |-> tap_state_r inside {`TS_SHIFT_DR, `TS_EXIT1_DR, `TS_SHIFT_IR, `TS_EXIT1_IR})
        else $error("tdo driven outside shift");
    a_shift_drives: assert property ((tap_state_r == `TS_SHIFT_DR)[*8] |-> tdo_oe)
        else $error("tdo not driven in shift");
    a_idle_exit: assert property ($changed(tap_state_r) && $past(tap_state_r) == `TS_IDLE && trst_n |-> tap_state_r == `TS_SEL_DR)
        else $error("bad move out of idle");
    cover property (tap_state_r == `TS_SHIFT_DR);
    cover property (tap_state_r == `TS_SHIFT_IR);
    cover property ($rose(tdo_oe));
endmodule
bind scan_test_port scan_port_props scan_port_props_inst (.clk(clk), .rst_n(rst_n), .tck(tck), .trst_n(trst_n),
    .trst_oe(trst_oe), .tdo_oe(tdo_oe), .tap_state_r(tap_state_r));

// ### sim/scan_tester_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// external tester model
// ----------------------------------------
module scan_tester_model (
    input  wire clk,
    input  wire tdo_w,
    output reg  tck     = 1'b1,
    output reg  tms     = 1'b1,
    output reg  tms_oe  = 1'b1,
    output reg  tdi     = 1'b1,
    output reg  tdi_oe  = 1'b1,
    output reg  trst_n  = 1'b1,
    output reg  trst_oe = 1'b1
);
    // one tck period, 4 clk low then 4 clk high; tck still between steps
    task step(input m, input i, output q);
        begin
            tck <= 1'b0;
            tms <= m;
            tdi <= i;
            repeat (4) @(posedge clk);
            tck <= 1'b1;
            repeat (2) @(posedge clk);
            q = tdo_w;
            repeat (2) @(posedge clk);
        end
    endtask
endmodule

// ### sim/scan_test_port_tb_top.sv
`timescale 1ns/1ps
`include "scan_port_defs.vh"
// ----------------------------------------
// bench
// ----------------------------------------
module scan_test_port_tb_top;
    localparam [31:0] ID = 32'h00005A3C;  // arbitrary value
    reg         clk = 1'b0;
    reg         rst_n = 1'b0;
    wire        tck, tms, tms_oe, tdi, tdi_oe, trst_n, trst_oe, tdo_r, tdo_oe, ptest;
    wire [3:0]  st;
    wire [7:0]  pout;
    wire        tdo_w = tdo_oe ? tdo_r : ~tdo_r;  // released line shows the inverse
    reg  [31:0] d;
    integer     err_count = 0;
    integer     tests_run = 0;
    always #10 clk = ~clk;
    scan_test_port #(.ID_CODE(ID)) scan_test_port_inst (.clk(clk), .rst_n(rst_n), .ce(1'b1), .tck(tck), .tms(tms),
        .tms_oe(tms_oe), .tdi(tdi), .tdi_oe(tdi_oe), .trst_n(trst_n), .trst_oe(trst_oe), .pin_in(8'hA5),
        .tdo_r(tdo_r), .tdo_oe(tdo_oe), .pin_out(pout), .pin_test_r(ptest), .tap_state_r(st));
    scan_tester_model scan_tester_model_inst (.clk(clk), .tdo_w(tdo_w), .tck(tck), .tms(tms), .tms_oe(tms_oe),
        .tdi(tdi), .tdi_oe(tdi_oe), .trst_n(trst_n), .trst_oe(trst_oe));
    task chk(input [63:0] n, input [31:0] e, input [31:0] g);
        begin
            tests_run = tests_run + 1;
            if (g !== e) begin
                err_count = err_count + 1;
                $display("Error %0s expected %h seen %h", n, e, g);
            end
        end
    endtask
    task st_at(input [3:0] e);
        begin
            @(negedge clk);
            chk("state", {28'h0, e}, {28'h0, st});
            @(posedge clk);
        end
    endtask
    task nav(input [7:0] s, input integer k);
        integer j;
        reg     q;
        for (j = 0; j < k; j = j + 1)
            scan_tester_model_inst.step(s[j], 1'b1, q);
    endtask
    task sh(input [31:0] i, input integer k);
        integer j;
        reg     q;
        begin
            d = 32'h0;
            for (j = 0; j < k; j = j + 1) begin
                scan_tester_model_inst.step(j == k - 1, i[j], q);
                d[j] = q;
            end
        end
    endtask
    task results;
        begin
            $display("checks %0d errors %0d", tests_run, err_count);
            if (err_count == 0 && tests_run > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    // idcode read, then tdo released
    task t_idcode;
        begin
            nav(8'h02, 4);
            sh(32'hFFFFFFFF, 32);
            chk("idcode", ID, d);
            nav(8'h01, 1);
            chk("tdo_oe", 32'h0, {31'h0, tdo_oe});
            nav(8'h00, 1);
        end
    endtask
    // load bypass through the instruction path, then shift data
    task t_ir;
        begin
            nav(8'h03, 4);
            sh(32'hF5, 8);
            chk("ir", 32'h51, d);
            nav(8'h05, 5);
            sh(32'h6, 4);
            chk("bypass", 32'hC, d);
            nav(8'h01, 2);
        end
    endtask
    // boundary path: load an op, read the pins, update the outputs, then reset
    task t_bsr(input [3:0] op, input [7:0] v, input tst);
        begin
            nav(8'h03, 4);
            sh({28'h0, op}, 4);
            chk("ir_cap", 32'h1, d);
            nav(8'h05, 5);
            sh({24'h0, v}, 8);
            chk("bsr", 32'hA5, d);
            nav(8'h01, 2);
            chk("pin_out", {24'h0, v}, {24'h0, pout});
            chk("pin_test", {31'h0, tst}, {31'h0, ptest});
            nav(8'h1F, 5);
            chk("pin_test", 32'h0, {31'h0, ptest});
            nav(8'h00, 1);
        end
    endtask
    // open trst, tms and tdi read high
    task t_open;
        begin
            scan_tester_model_inst.trst_oe <= 1'b0;
            scan_tester_model_inst.trst_n <= 1'b0;
            repeat (8) @(posedge clk);
            st_at(`TS_IDLE);
            scan_tester_model_inst.trst_oe <= 1'b1;
            scan_tester_model_inst.trst_n <= 1'b1;
            scan_tester_model_inst.tms_oe <= 1'b0;
            nav(8'h00, 5);
            st_at(`TS_RESET);
            scan_tester_model_inst.tms_oe <= 1'b1;
            nav(8'h00, 1);
            scan_tester_model_inst.tdi_oe <= 1'b0;
            nav(8'h03, 4);
            sh(32'h0, 8);
            chk("tdi_open", 32'hF1, d);
            scan_tester_model_inst.tdi_oe <= 1'b1;
            nav(8'h01, 2);
        end
    endtask
    // trst with tck standing still
    task t_trst;
        begin
            scan_tester_model_inst.trst_n <= 1'b0;
            repeat (6) @(posedge clk);
            st_at(`TS_RESET);
            scan_tester_model_inst.trst_n <= 1'b1;
            repeat (4) @(posedge clk);
        end
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        st_at(`TS_RESET);
        t_idcode;
        t_ir;
        t_bsr(`IR_SAMPLE, 8'h3C, 1'b0);
        t_bsr(`IR_EXTEST, 8'hC3, 1'b1);
        t_open;
        t_trst;
        results;
    end
    initial begin
        repeat (5000) @(posedge clk);
        err_count = err_count + 1;
        results;
    end
endmodule
